// ===== verilog/oms_mode_bank.sv
// Contract
// - mode field codes: standby, wake, sleep, trigger
// - strap grounded: come up in standby
// - strap high, motion high: come up wake
// - no trigger mode while strap high
// - awaiting trigger reports trigger mode code
// - measurement reports wake, then back to trigger
// - wake output level on selected irq pin
// - entering measuring mode clears debounce counters
// - config register fields at 15h, read/write except soft reset bit, which the reload clears
// - config defaults follow boot strap
//
// Purpose: operating-mode status and primary sensor configuration
// Assumes: inputs synchronous to i_mclk; strap stable around reset
// Notes: soft reset reloads defaults one cycle after the write
`timescale 1ns/1ps
`include "oms_regs.svh"
module oms_mode_bank
   import oms_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_boot_strap_pin,
   input wire logic i_motion_detect_output,
   input wire logic i_pin2_function_select,
   input wire logic i_trigger,
   input wire logic i_meas_done,
   input wire logic i_sleep_request,
   input wire logic i_wake_request,
   input wire logic i_wake_output_enable,
   input wire logic i_wake_output_pin_select,
   input wire logic i_irq_polarity,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic [1:0] o_operating_mode,
   output oms_cfg_t o_sensor_config,
   output logic o_debounce_clear,
   output oms_pin_t o_irq_pin_one,
   output oms_pin_t o_irq_pin_two
);
   logic boot_pending_reg;
   logic soft_reset_reg;
   logic load_defaults;
   logic cfg_wr;
   logic [7:0] cfg_default;
   logic [7:0] cfg_value;
   oms_cfg_t cfg;
   oms_state_t state_reg;
   oms_state_t state_next;
   logic [1:0] mode_code;
   logic [1:0] mode_reg;
   logic trig_allowed;

   // strap is caught on the first enabled edge after release, never in reset
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         boot_pending_reg <= 1'b1;
      else if (i_ce)
         boot_pending_reg <= 1'b0;
   end

   // only the config offset is writable; mode offset has no write path
   assign cfg_wr = i_reg_wr && (i_reg_addr == `OMS_ADDR_CFG1);

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         soft_reset_reg <= 1'b0;
      else if (i_ce)
         soft_reset_reg <= cfg_wr && i_reg_wdata[`OMS_CFG1_RST_BIT];
   end

   assign load_defaults = boot_pending_reg || soft_reset_reg;
   assign cfg_default = i_boot_strap_pin ? `OMS_CFG1_RESET_VDD
                                         : `OMS_CFG1_RESET_GND;

   oms_cfg_reg #(.WIDTH(8)) u_cfg1
   (
      .i_mclk(i_mclk),
      .i_resetn(i_resetn),
      .i_ce(i_ce),
      .i_load(load_defaults),
      .i_default(cfg_default),
      .i_wr(cfg_wr),
      .i_wdata(i_reg_wdata),
      .o_value(cfg_value)
   );
   assign cfg = oms_cfg_t'(cfg_value);

   assign trig_allowed = i_pin2_function_select && !i_boot_strap_pin;

   always_comb
   begin
      state_next = state_reg;
      if (load_defaults)
      begin
         if (!i_boot_strap_pin)
            state_next = OMS_ST_STANDBY;
         else if (i_motion_detect_output)
            state_next = OMS_ST_WAKE;
         else
            state_next = OMS_ST_SLEEP;
      end
      else if (!cfg.active)
         state_next = OMS_ST_STANDBY;
      else
      begin
         unique case (state_reg)
            OMS_ST_STANDBY:
               state_next = trig_allowed ? OMS_ST_TRIG_WAIT : OMS_ST_WAKE;
            OMS_ST_WAKE:
            begin
               if (trig_allowed)
                  state_next = OMS_ST_TRIG_WAIT;
               else if (i_sleep_request)
                  state_next = OMS_ST_SLEEP;
            end
            OMS_ST_SLEEP:
            begin
               if (trig_allowed)
                  state_next = OMS_ST_TRIG_WAIT;
               else if (i_wake_request)
                  state_next = OMS_ST_WAKE;
            end
            OMS_ST_TRIG_WAIT:
            begin
               if (!trig_allowed)
                  state_next = OMS_ST_WAKE;
               else if (i_trigger)
                  state_next = OMS_ST_TRIG_MEAS;
            end
            OMS_ST_TRIG_MEAS:
            begin
               if (i_meas_done)
                  state_next = OMS_ST_TRIG_WAIT;
            end
            default:
               state_next = OMS_ST_STANDBY;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         state_reg <= OMS_ST_STANDBY;
      else if (i_ce)
         state_reg <= state_next;
   end

   always_comb
   begin
      unique case (state_reg)
         OMS_ST_WAKE: mode_code = `OMS_MODE_WAKE;
         OMS_ST_SLEEP: mode_code = `OMS_MODE_SLEEP;
         OMS_ST_TRIG_WAIT: mode_code = `OMS_MODE_TRIG;
         OMS_ST_TRIG_MEAS: mode_code = `OMS_MODE_WAKE;
         default: mode_code = `OMS_MODE_STANDBY;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         mode_reg <= `OMS_MODE_STANDBY;
         o_debounce_clear <= 1'b0;
      end
      else if (i_ce)
      begin
         mode_reg <= mode_code;
         // one pulse per change into any measuring code
         o_debounce_clear <= (mode_code != mode_reg)
                             && (mode_code != `OMS_MODE_STANDBY);
      end
   end
   assign o_operating_mode = mode_reg;

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_sensor_config <= '0;
      else if (i_ce)
         o_sensor_config <= cfg;
   end

   // pins released (oe_n high) unless the wake level is being driven
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_irq_pin_one <= '{level: 1'b0, oe_n: 1'b1};
         o_irq_pin_two <= '{level: 1'b0, oe_n: 1'b1};
      end
      else if (i_ce)
      begin
         o_irq_pin_one.level <= i_irq_polarity;
         o_irq_pin_two.level <= i_irq_polarity;
         o_irq_pin_one.oe_n <= !(i_wake_output_enable && mode_code == `OMS_MODE_WAKE
                                 && !i_wake_output_pin_select);
         o_irq_pin_two.oe_n <= !(i_wake_output_enable && mode_code == `OMS_MODE_WAKE
                                 && i_wake_output_pin_select);
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_reg_rdata <= 8'h00;
      else if (i_ce && i_reg_rd)
      begin
         // upper mode bits belong to buffer logic outside; read as zero here
         if (i_reg_addr == `OMS_ADDR_MODE)
            o_reg_rdata <= {6'h00, mode_reg};
         else if (i_reg_addr == `OMS_ADDR_CFG1)
            o_reg_rdata <= cfg_value;
         else
            o_reg_rdata <= 8'h00;
      end
   end
endmodule

// ===== verilog/oms_regs.svh
// Purpose: offsets, field positions, reset values of the mode/config bank
// Assumes: byte-wide register port
// Notes: definitions only
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH
`define OMS_ADDR_MODE 8'h14
`define OMS_ADDR_CFG1 8'h15
`define OMS_CFG1_RST_BIT 7
`define OMS_CFG1_ACTIVE_BIT 0
`define OMS_CFG1_RESET_GND 8'h00
`define OMS_CFG1_RESET_VDD 8'h03
`define OMS_MODE_STANDBY 2'h0
`define OMS_MODE_WAKE 2'h1
`define OMS_MODE_SLEEP 2'h2
`define OMS_MODE_TRIG 2'h3
`endif

// ===== verilog/oms_pkg.sv
// Purpose: types of the mode/config bank
// Assumes: nothing
// Notes: field layout matches sensor_config_one bit order
package oms_pkg;
   typedef struct packed {
      logic soft_reset;
      logic [1:0] selftest_axis_select;
      logic selftest_polarity;
      logic serial_wire_mode;
      logic [1:0] full_scale_range;
      logic active;
   } oms_cfg_t;

   typedef enum logic [4:0] {
      OMS_ST_STANDBY = 5'h01,
      OMS_ST_WAKE = 5'h02,
      OMS_ST_SLEEP = 5'h04,
      OMS_ST_TRIG_WAIT = 5'h08,
      OMS_ST_TRIG_MEAS = 5'h10
   } oms_state_t;

   typedef struct packed {
      logic level;
      logic oe_n;
   } oms_pin_t;
endpackage

// ===== verilog/oms_cfg_reg.sv
// Purpose: one read/write register with strap-dependent default reload
// Assumes: default value stable while reload is requested
// Notes: async reset gives zero; defaults land on reload
`timescale 1ns/1ps
module oms_cfg_reg
#(
   parameter int WIDTH = 8
)
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_default,
   input wire logic i_wr,
   input wire logic [WIDTH-1:0] i_wdata,
   output logic [WIDTH-1:0] o_value
);
   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_value <= '0;
      else if (i_ce)
      begin
         // reload beats a write in the same cycle
         if (i_load)
            o_value <= i_default;
         else if (i_wr)
            o_value <= i_wdata;
      end
   end
endmodule

// ===== dv/oms_mode_bank_checker.sv
// Purpose: port checker for oms_mode_bank
// Assumes: one clock, async low reset
// Notes: bound below
`timescale 1ns/1ps
module oms_mode_bank_checker
   import oms_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_ce,
   input wire logic i_boot_strap_pin,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [1:0] o_operating_mode,
   input wire oms_cfg_t o_sensor_config,
   input wire logic o_debounce_clear,
   input wire oms_pin_t o_irq_pin_one,
   input wire oms_pin_t o_irq_pin_two
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_resetn);
   a_strap_no_trig: assert property (i_boot_strap_pin |-> o_operating_mode != 2'h3)
      else $error("trigger mode with strap high");
   a_pin_one_wake: assert property (!o_irq_pin_one.oe_n |-> o_operating_mode == 2'h1)
      else $error("pin one driven outside wake");
   a_pin_two_wake: assert property (!o_irq_pin_two.oe_n |-> o_operating_mode == 2'h1)
      else $error("pin two driven outside wake");
   a_clear_on_entry: assert property (
      $changed(o_operating_mode) && o_operating_mode != 2'h0
      |-> o_debounce_clear) else $error("no debounce clear on entry");
   a_clear_cause: assert property (o_debounce_clear
      |-> $changed(o_operating_mode) && o_operating_mode != 2'h0) else $error("stray clear");
   a_unmapped_zero: assert property (i_ce && i_reg_rd && i_reg_addr != 8'h14
      && i_reg_addr != 8'h15 |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_hold: assert property (!(i_ce && i_reg_rd) |=> $stable(o_reg_rdata))
      else $error("read data moved");
   a_cfg_write: assert property (
      i_ce && i_reg_wr && i_reg_addr == 8'h15 && !i_reg_wdata[7] ##1 !i_reg_wr
      |=> o_sensor_config == $past(i_reg_wdata, 2)) else $error("config lost");
   c_trig: cover property (o_operating_mode == 2'h3);
   c_sleep: cover property (o_operating_mode == 2'h2);
   c_pin: cover property (!o_irq_pin_two.oe_n);
endmodule
bind oms_mode_bank oms_mode_bank_checker i_chk (.*);

// ===== dv/oms_meas_model.sv
// Purpose: measurement engine at the far side
// Assumes: trigger taken when mode goes 11 to 01
// Notes: done pulse DELAY cycles later
`timescale 1ns/1ps
module oms_meas_model
#(
   parameter int DELAY = 6
)
(
   input wire logic i_mclk,
   input wire logic [1:0] i_mode,
   output logic o_meas_done
);
   logic [1:0] prev_reg = 2'h0;
   logic done_reg = 1'b0;
   int cnt = 0;
   // single driver for the done pulse
   assign o_meas_done = done_reg;
   always @(negedge i_mclk)
   begin
      done_reg <= (cnt == 1);
      if (prev_reg == 2'h3 && i_mode == 2'h1)
         cnt <= DELAY;
      else if (cnt != 0)
         cnt <= cnt - 1;
      prev_reg <= i_mode;
   end
endmodule

// ===== dv/tb_oms_mode_bank.sv
// Purpose: register-level tests of oms_mode_bank
// Assumes: inputs driven on falling edge
// Notes: i_ce dropped once to check that state freezes
`timescale 1ns/1ps
module tb_oms_mode_bank
   import oms_pkg::*;
;
   logic mclk = 0, rstn = 0, strap = 0, mot = 0, p2 = 0, trig = 0, slp = 0, wk = 0;
   logic woe = 0, wsel = 0, pol = 0, wr = 0, rd = 0, ce = 1, dclr, mdone;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
   logic [1:0] mode;
   oms_cfg_t cfg;
   oms_pin_t p1o, p2o;
   int errors = 0, check_count = 0;
   oms_mode_bank i_dut (.i_mclk(mclk), .i_resetn(rstn), .i_ce(ce), .i_boot_strap_pin(strap),
      .i_motion_detect_output(mot), .i_pin2_function_select(p2), .i_trigger(trig),
      .i_meas_done(mdone), .i_sleep_request(slp), .i_wake_request(wk),
      .i_wake_output_enable(woe), .i_wake_output_pin_select(wsel), .i_irq_polarity(pol),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
      .o_operating_mode(mode), .o_sensor_config(cfg), .o_debounce_clear(dclr),
      .o_irq_pin_one(p1o), .o_irq_pin_two(p2o));
   oms_meas_model #(.DELAY(6)) i_meas (.i_mclk(mclk), .i_mode(mode), .o_meas_done(mdone));
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // trailing idle lets mode settle two edges after the write
   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(3);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      chk(rdata, exp);
      // idle edge so a following read never re-raises rd in this time step
      tick(1);
   endtask
   task automatic boot(input logic s, input logic m);
      rstn = 1'b0;
      strap = s;
      mot = m;
      tick(12);
      rstn = 1'b1;
      tick(3);
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #200000;
      errors++;
      summarize;
   end
   initial
   begin
      boot(1'b0, 1'b0);
      rdc(8'h15, 8'h00);
      rdc(8'h14, 8'h00);
      rdc(8'h20, 8'h00);
      wrt(8'h14, 8'hFF);
      rdc(8'h14, 8'h00);
      $display("test defaults done");
      woe = 1'b1;
      wsel = 1'b1;
      pol = 1'b1;
      wrt(8'h15, 8'h6D);
      rdc(8'h15, 8'h6D);
      chk(cfg, 8'h6D);
      rdc(8'h14, 8'h01);
      chk({5'h00, p1o.oe_n, p2o.oe_n, p2o.level}, 8'h05);
      // enable low: this write must not land
      ce = 1'b0;
      wrt(8'h15, 8'h00);
      ce = 1'b1;
      rdc(8'h15, 8'h6D);
      slp = 1'b1;
      tick(4);
      slp = 1'b0;
      rdc(8'h14, 8'h02);
      chk({6'h00, p1o.oe_n, p2o.oe_n}, 8'h03);
      wk = 1'b1;
      wsel = 1'b0;
      pol = 1'b0;
      tick(4);
      wk = 1'b0;
      rdc(8'h14, 8'h01);
      chk({5'h00, p2o.oe_n, p1o.oe_n, p1o.level}, 8'h04);
      $display("test wake pins done");
      wrt(8'h15, 8'h00);
      p2 = 1'b1;
      wrt(8'h15, 8'h01);
      rdc(8'h14, 8'h03);
      trig = 1'b1;
      tick(1);
      trig = 1'b0;
      tick(1);
      chk({5'h00, dclr, mode}, 8'h05);
      tick(1);
      chk({6'h00, mode}, 8'h01);
      tick(12);
      rdc(8'h14, 8'h03);
      $display("test trigger done");
      wrt(8'h15, 8'h80);
      rdc(8'h15, 8'h00);
      rdc(8'h14, 8'h00);
      boot(1'b1, 1'b1);
      rdc(8'h15, 8'h03);
      rdc(8'h14, 8'h01);
      wrt(8'h15, 8'h03);
      rdc(8'h14, 8'h01);
      $display("test strap high done");
      summarize;
   end
endmodule
